// ---- zf_regs.svh ----
// Register map, field positions, reset values and counts for the
// zero-flag, general-output and oversampling control block.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
//
// Functional notes
// - 256-768 fs clock: select gives 64x/128x.
// - 128/192 fs clock: select gives 32x/64x.
// - Above 96 kHz the 32x/64x pair applies.
// - Enable picks zero flags or general outputs.
// - General bits drive pins, read/write, reset zero.
// - Zero detect after 1024 zero word periods.
// - Detecting channel flag pin goes high.
// - All-channel flag is AND of eight.
// - Polarity bit makes flags active low.
// - Control word bits seven, six, five-zero.
`ifndef ZF_REGS_SVH
`define ZF_REGS_SVH

// ==========================================================
// Register byte offsets
`define ZF_CTRL_OFS 8'h00
`define ZF_CFG_OFS 8'h04
`define ZF_STAT_OFS 8'h08
`define ZF_IRQ_STAT_OFS 8'h0C
`define ZF_IRQ_MASK_OFS 8'h10

// ==========================================================
// Control word fields
`define ZF_OS_SEL_BIT 7
`define ZF_GPO_EN_BIT 6
`define ZF_GPO_MSB 5
`define ZF_GPO_LSB 0

// ==========================================================
// Configuration word fields
`define ZF_RATIO_MSB 2
`define ZF_RATIO_LSB 0
`define ZF_HIGH_RATE_BIT 3
`define ZF_POL_BIT 4

// ==========================================================
// Status word fields
`define ZF_STAT_ALL_BIT 8
`define ZF_STAT_RATE_MSB 10
`define ZF_STAT_RATE_LSB 9

// ==========================================================
// Reset values and counts
`define ZF_CTRL_RST 8'h00
`define ZF_CFG_RST 5'h00
`define ZF_IRQ_RST 9'h000
`define ZF_ZERO_RUN_LEN 1024

`endif

// ---- zf_pkg.sv ----
// Types shared by the zero-flag control block and its helpers.
// Assumes the constants of zf_regs.svh for field widths.
package zf_pkg;

   // ==========================================================
   // Ratio of system clock to sample rate, as software declares it.
   typedef enum logic [2:0] {
      ratio_128, ratio_192, ratio_256, ratio_384, ratio_512, ratio_768
   } clk_ratio_t;

   // Resulting modulator oversampling rate.
   typedef enum logic [1:0] {os_32x, os_64x, os_128x} os_rate_t;

   // ==========================================================
   // State of the top block.
   typedef struct packed {
      logic os_sel;          // Oversampling select bit.
      logic gpo_en;          // General output enable.
      logic [5:0] gpo_bits;  // General output levels.
      logic [2:0] ratio;     // Declared clock ratio code.
      logic high_rate;       // Sample rate above 96 kHz.
      logic polarity;        // Zero-flag polarity, one is active low.
      logic [8:0] irq_stat;  // Sticky event bits.
      logic [8:0] irq_mask;  // Interrupt enables.
      logic wr_pend;         // Write data phase follows.
      logic [7:0] wr_addr;   // Address of pending write.
      logic [31:0] hrdata;   // Read data register.
      logic [5:0] shared_pin;  // Shared zero/general pins.
      logic flag7;           // Channel seven flag pin.
      logic flag8;           // Channel eight flag pin.
      logic flag_all;        // All-channel flag pin.
      logic irq;             // Interrupt output.
      logic wclk_d;          // Delayed word clock for edge finding.
      logic [7:0] det_q;     // Previous detects for event edges.
      logic all_q;           // Previous all-channel detect.
   } top_state_t;

   // State of one zero-run counter.
   typedef struct packed {
      logic [10:0] cnt;
      logic detect;
   } run_state_t;

endpackage

// ---- zero_run_detect.sv ----
// One channel's zero-run detector.
// Assumes a one-cycle word clock tick and a level that is high while
// the channel's current sample is all zeros.
`timescale 1ns/1ps
`default_nettype none
`include "zf_regs.svh"

module zero_run_detect import zf_pkg::*; #(
   parameter int RUN_LEN = `ZF_ZERO_RUN_LEN
) (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Sample status.
   input wire logic i_tick,
   input wire logic i_data_zero,
   // Detect result.
   output logic o_detect
);

   // ==========================================================
   // State
   run_state_t s;      // Registered state.
   run_state_t next_s; // Next state.

   // A nonzero sample wins over the tick, so a run never survives one.
   always_comb begin
      next_s = s;
      if (!i_data_zero) begin
         next_s.cnt = 11'h000;
         next_s.detect = 1'b0;
      end else if (i_tick && !s.detect) begin
         next_s.cnt = s.cnt + 11'h001;
         // Detect on the last of the consecutive zero periods.
         next_s.detect = (next_s.cnt == 11'(RUN_LEN));
      end
   end

   // Register the whole state.
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_detect = s.detect;

   // ==========================================================
   // Checks
   a_zero_clears: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      !i_data_zero |=> !o_detect && s.cnt == 11'h000)
      else $error("zero run not cleared by nonzero sample");
   a_run_length: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      $rose(o_detect) |-> $past(s.cnt) == 11'(RUN_LEN - 1))
      else $error("zero detect at wrong run length");

endmodule
`default_nettype wire

// ---- os_rate_select.sv ----
// Resolves the modulator oversampling rate.
// Assumes software declares the clock ratio and the sample rate band.
`timescale 1ns/1ps
`default_nettype none
`include "zf_regs.svh"

module os_rate_select import zf_pkg::*; (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Settings.
   input wire logic [2:0] i_ratio,
   input wire logic i_high_rate,
   input wire logic i_os_sel,
   // Result.
   output os_rate_t o_rate
);

   // ==========================================================
   // State
   os_rate_t s;      // Registered rate.
   os_rate_t next_s; // Next rate.
   logic low_pair;   // The 32x/64x pair applies.

   // Slow clock ratios or high sample rates only leave room for the
   // lower pair; otherwise the upper pair applies.
   always_comb begin
      low_pair = (i_ratio == ratio_128) || (i_ratio == ratio_192)
         || i_high_rate;
      if (low_pair) begin
         next_s = i_os_sel ? os_64x : os_32x;
      end else begin
         next_s = i_os_sel ? os_128x : os_64x;
      end
   end

   // Register the rate; reset gives the cleared-select upper pair.
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s <= os_64x;
      end else begin
         s <= next_s;
      end
   end

   assign o_rate = s;

   // ==========================================================
   // Checks
   a_upper_pair: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (!low_pair && i_os_sel) |=> o_rate == os_128x)
      else $error("upper pair select not giving 128x");
   a_lower_pair: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (low_pair && !i_os_sel) |=> o_rate == os_32x)
      else $error("lower pair clear not giving 32x");

endmodule
`default_nettype wire

// ---- zero_flag_gpo_oversample_ctrl.sv ----
// Top of the zero-flag, general-output and oversampling control block.
// Assumes an AHB-Lite master with single word transfers, a word clock
// and per-channel zero indications synchronous to i_mclk.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "zf_regs.svh"

module zero_flag_gpo_oversample_ctrl import zf_pkg::*; #(
   parameter int CHANNELS = 8,
   parameter int RUN_LEN = `ZF_ZERO_RUN_LEN
) (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // AHB-Lite slave port.
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic [31:0] o_hrdata,
   output logic o_hresp,
   // Audio timing and sample status.
   input wire logic i_word_clock,
   input wire logic [7:0] i_chan_data_zero,
   // Flag and general output pins.
   output logic [5:0] o_shared_pin,
   output logic o_channel_seven_zero_flag,
   output logic o_channel_eight_zero_flag,
   output logic o_all_channel_zero_flag,
   // Oversampling rate to the modulators.
   output logic [1:0] o_os_rate,
   // Interrupt.
   output logic o_irq
);

   // ==========================================================
   // Declarations
   top_state_t s;        // Registered state.
   top_state_t next_s;   // Next state.
   logic tick;           // One cycle at each word clock rising edge.
   logic [7:0] det;      // Per-channel zero-detect conditions.
   logic all_det;        // Every channel detects zero.
   logic [8:0] clr;      // Write-one-to-clear mask of this cycle.
   logic [8:0] ev;       // Event set pulses of this cycle.
   logic addr_phase;     // A transfer is taken this cycle.
   os_rate_t rate;       // Resolved oversampling rate.
   logic hready_q;       // Registered ready, low in reset, high from the first edge after.

   // ==========================================================
   // Word clock edge
   // The word clock is taken as a synchronous level, so one delayed
   // copy is enough to mark each new sample period.
   assign tick = i_word_clock && !s.wclk_d;

   // ==========================================================
   // Per-channel zero-run detectors
   // Each channel counts on its own; none waits for another.
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
         zero_run_detect #(
            .RUN_LEN(RUN_LEN)
         ) u_run (
            .i_mclk(i_mclk),
            .i_arst_n(i_arst_n),
            .i_tick(tick),
            .i_data_zero(i_chan_data_zero[ch]),
            .o_detect(det[ch])
         );
      end
   endgenerate

   // The combined condition needs every channel at once.
   assign all_det = &det;

   // ==========================================================
   // Oversampling rate resolver
   os_rate_select u_rate (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_ratio(s.ratio),
      .i_high_rate(s.high_rate),
      .i_os_sel(s.os_sel),
      .o_rate(rate)
   );

   // ==========================================================
   // Read multiplexer
   // Reads see the state after any write of the same cycle, so a read
   // straight after a write returns the new value with no wait state.
   function automatic logic [31:0] read_word(input top_state_t t,
                                             input logic [7:0] a,
                                             input logic [7:0] d,
                                             input logic ad,
                                             input logic [1:0] r);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (a == `ZF_CTRL_OFS) begin
         w[`ZF_OS_SEL_BIT] = t.os_sel;
         w[`ZF_GPO_EN_BIT] = t.gpo_en;
         w[`ZF_GPO_MSB:`ZF_GPO_LSB] = t.gpo_bits;
      end else if (a == `ZF_CFG_OFS) begin
         w[`ZF_RATIO_MSB:`ZF_RATIO_LSB] = t.ratio;
         w[`ZF_HIGH_RATE_BIT] = t.high_rate;
         w[`ZF_POL_BIT] = t.polarity;
      end else if (a == `ZF_STAT_OFS) begin
         w[7:0] = d;
         w[`ZF_STAT_ALL_BIT] = ad;
         w[`ZF_STAT_RATE_MSB:`ZF_STAT_RATE_LSB] = r;
      end else if (a == `ZF_IRQ_STAT_OFS) begin
         w[8:0] = t.irq_stat;
      end else if (a == `ZF_IRQ_MASK_OFS) begin
         w[8:0] = t.irq_mask;
      end
      // Unmapped addresses read as zero.
      return w;
   endfunction

   // ==========================================================
   // Next-state logic
   // Bus writes land in the data phase; events, pins and the interrupt
   // are all worked out here so that one register stage holds them.
   always_comb begin
      next_s = s;
      clr = 9'h000;
      next_s.wclk_d = i_word_clock;
      addr_phase = i_hsel && i_htrans[1] && i_hready;

      // Data phase of a write: only mapped, writable words change.
      if (s.wr_pend) begin
         if (s.wr_addr == `ZF_CTRL_OFS) begin
            next_s.os_sel = i_hwdata[`ZF_OS_SEL_BIT];
            next_s.gpo_en = i_hwdata[`ZF_GPO_EN_BIT];
            next_s.gpo_bits =
               i_hwdata[`ZF_GPO_MSB:`ZF_GPO_LSB];
         end else if (s.wr_addr == `ZF_CFG_OFS) begin
            next_s.ratio = i_hwdata[`ZF_RATIO_MSB:`ZF_RATIO_LSB];
            next_s.high_rate = i_hwdata[`ZF_HIGH_RATE_BIT];
            next_s.polarity = i_hwdata[`ZF_POL_BIT];
         end else if (s.wr_addr == `ZF_IRQ_STAT_OFS) begin
            clr = i_hwdata[8:0];
         end else if (s.wr_addr == `ZF_IRQ_MASK_OFS) begin
            next_s.irq_mask = i_hwdata[8:0];
         end
         // Status and unmapped words ignore writes.
      end

      // Events are the onset of each detect condition.
      ev = {all_det && !s.all_q, det & ~s.det_q};
      next_s.det_q = det;
      next_s.all_q = all_det;
      // A set in the same cycle as its clear wins, so no event is lost.
      next_s.irq_stat = (s.irq_stat & ~clr) | ev;

      // Address phase: remember writes, answer reads next cycle.
      next_s.wr_pend = 1'b0;
      if (addr_phase) begin
         next_s.wr_pend = i_hwrite;
         next_s.wr_addr = i_haddr[7:0];
         if (!i_hwrite) begin
            next_s.hrdata = read_word(next_s, i_haddr[7:0], det, all_det,
                                      rate);
         end
      end

      // Shared pins follow the enable: general levels or zero flags.
      if (s.gpo_en) begin
         next_s.shared_pin = s.gpo_bits;
      end else begin
         next_s.shared_pin = det[5:0] ^ {6{s.polarity}};
      end
      // The remaining flags always show detection.
      next_s.flag7 = det[6] ^ s.polarity;
      next_s.flag8 = det[7] ^ s.polarity;
      next_s.flag_all = all_det ^ s.polarity;

      // One level interrupt while any unmasked status bit stands.
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
   end

   // ==========================================================
   // State register
   // Everything resets to the documented defaults: flags active high,
   // general outputs off, oversampling select cleared.
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s <= '0;
         hready_q <= 1'b0;
      end else begin
         s <= next_s;
         hready_q <= 1'b1;
      end
   end

   // ==========================================================
   // Outputs, all but the tied-off o_hresp taken from flip-flops
   // Ready is low only during reset; the bus never sees wait states.
   assign o_hreadyout = hready_q;
   assign o_hrdata = s.hrdata;
   assign o_hresp = 1'b0;
   assign o_shared_pin = s.shared_pin;
   assign o_channel_seven_zero_flag = s.flag7;
   assign o_channel_eight_zero_flag = s.flag8;
   assign o_all_channel_zero_flag = s.flag_all;
   assign o_os_rate = rate;
   assign o_irq = s.irq;

   // ==========================================================
   // Checks

   // A write to the control word: address phase then its data phase.
   sequence s_ctrl_addr;
      i_hsel && i_htrans[1] && i_hready && i_hwrite
         && i_haddr[7:0] == `ZF_CTRL_OFS;
   endsequence

   sequence s_ctrl_write;
      s_ctrl_addr ##1 1'b1;
   endsequence

   // The data word reaches the control fields one edge after the
   // data phase.
   a_ctrl_write: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      s_ctrl_write |=> s.os_sel == $past(i_hwdata[`ZF_OS_SEL_BIT])
         && s.gpo_en == $past(i_hwdata[`ZF_GPO_EN_BIT])
         && s.gpo_bits == $past(i_hwdata[5:0]))
      else $error("control word write lost or misplaced");

   // General outputs drive the written levels.
   a_gpo_levels: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      s.gpo_en |=> o_shared_pin == $past(s.gpo_bits))
      else $error("general output pins differ from written bits");

   // With general outputs off the pins carry channels one to six.
   a_zero_route: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      !s.gpo_en |=> o_shared_pin == ($past(det[5:0])
         ^ {6{$past(s.polarity)}}))
      else $error("shared pins not carrying zero flags");

   // Channel seven and eight flags follow their detectors.
   a_high_flags: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      ##1 {o_channel_eight_zero_flag, o_channel_seven_zero_flag}
         == ($past(det[7:6]) ^ {2{$past(s.polarity)}}))
      else $error("channel seven or eight flag wrong");

   // The combined flag is the AND of all channels.
   a_all_flag: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (&det && !s.polarity) |=> o_all_channel_zero_flag)
      else $error("all-channel flag not set when all detect");

   // Polarity one turns a detect into a low pin.
   a_polarity: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (det[6] && s.polarity) |=> !o_channel_seven_zero_flag)
      else $error("polarity select not inverting flags");

   // A channel that drops out of detection clears the combined flag.
   a_all_drop: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (!det[0] && !s.polarity) |=> !o_all_channel_zero_flag)
      else $error("all-channel flag set with a channel active");

   // A new detection is never lost to a clear in the same cycle.
   a_set_wins: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (det[0] && !s.det_q[0]) |=> s.irq_stat[0])
      else $error("zero detect event lost");

   // The interrupt is high in every cycle in which an unmasked status bit stands.
   a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      |(s.irq_stat & s.irq_mask) |-> o_irq)
      else $error("interrupt low with unmasked status set");

   // The modulator rate tracks the select at a slow clock ratio.
   a_rate_low: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s.ratio == ratio_192 && s.os_sel) [*2] |-> rate == os_64x)
      else $error("192 fs with select set not giving 64x");

   // At a fast clock ratio and low sample rate the upper pair holds.
   a_rate_high: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s.ratio == ratio_512 && !s.high_rate && !s.os_sel) [*2]
         |-> rate == os_64x)
      else $error("512 fs with select clear not giving 64x");

   // A written one clears a status bit when no event sets it in the
   // same cycle.
   a_irq_clear: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s.wr_pend && s.wr_addr == `ZF_IRQ_STAT_OFS && i_hwdata[0]
         && !(det[0] && !s.det_q[0])) |=> !s.irq_stat[0])
      else $error("status bit not cleared by a written one");

   // The onset of the combined condition is an event of its own.
   a_all_event: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (all_det && !s.all_q) |=> s.irq_stat[8])
      else $error("all-channel onset not recorded");

   // Every channel records the onset of its own detection.
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_evt
         a_chan_event: assert property (@(posedge i_mclk)
            disable iff (!i_arst_n)
            (det[ch] && !s.det_q[ch]) |=> s.irq_stat[ch])
            else $error("channel detect onset not recorded");
      end
   endgenerate

   // A control read with no write pending returns the stored fields.
   a_read_ctrl: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (addr_phase && !i_hwrite && i_haddr[7:0] == `ZF_CTRL_OFS
         && !s.wr_pend) |=> o_hrdata == {24'h00_0000, $past(s.os_sel),
         $past(s.gpo_en), $past(s.gpo_bits)})
      else $error("control word read back wrong");

   // A configuration read returns ratio, rate band and polarity.
   a_read_cfg: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (addr_phase && !i_hwrite && i_haddr[7:0] == `ZF_CFG_OFS
         && !s.wr_pend) |=> o_hrdata == {27'h000_0000, $past(s.polarity),
         $past(s.high_rate), $past(s.ratio)})
      else $error("configuration word read back wrong");

   // A status read shows the live detects and the combined detect.
   a_read_stat: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (addr_phase && !i_hwrite && i_haddr[7:0] == `ZF_STAT_OFS)
         |=> o_hrdata[8:0] == {$past(all_det), $past(det)})
      else $error("status word read back wrong");

   // With default polarity an idle channel keeps its pin low.
   a_flag_idle: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (!det[6] && !s.polarity) |=> !o_channel_seven_zero_flag)
      else $error("channel seven flag high without detection");

   // Channel eight drives its own pin high on detection.
   a_flag_eight: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (det[7] && !s.polarity) |=> o_channel_eight_zero_flag)
      else $error("channel eight flag low at detection");

   // A fully masked interrupt stays low; only a pending write unmasks.
   a_irq_masked: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      (s.irq_mask == 9'h000 && !s.wr_pend) |=> !o_irq)
      else $error("interrupt raised while fully masked");

endmodule
`default_nettype wire

// ---- zf_sample_src.sv ----
// Behavioural sample source standing in for the audio front end.
// Assumes the bench chooses which channels carry all-zero samples.
`timescale 1ns/1ps
`default_nettype none

module zf_sample_src (
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Bench control.
   input wire logic [7:0] i_zero_mask,
   // Word clock and per-channel zero levels.
   output logic o_word_clock,
   output logic [7:0] o_chan_data_zero
);
   // ==========================================================
   // Word clock and sample status
   logic [1:0] div;  // Phase counter of the word clock.

   // Two cycles high and two low give one sample period per four
   // cycles, so ticks never come closer than the detector accepts.
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div <= 2'h0;
         o_chan_data_zero <= 8'h00;
      end else begin
         div <= div + 2'h1;
         o_chan_data_zero <= i_zero_mask;
      end
   end
   assign o_word_clock = div[1];
endmodule
`default_nettype wire

// ---- zero_flag_gpo_oversample_ctrl_tb_top.sv ----
// Self-checking bench for the zero-flag and oversampling block.
// Assumes a single AHB-Lite master and the sample source model.
`timescale 1ns/1ps
`default_nettype none
`include "zf_regs.svh"

module zero_flag_gpo_oversample_ctrl_tb_top;
   // ==========================================================
   // Signals
   localparam int RL = 8;  // Short zero run keeps the run brief.
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   logic [1:0] htrans = 2'h0, os_rate;
   logic hready, hresp, wclk, f7, f8, fall, irq;
   logic [7:0] zmask = 8'h00, zero;
   logic [5:0] pin;
   int fail_count = 0, n_checks = 0;
   // Rows: select, high rate, ratio code, expected rate code.
   // The last row is the host's choice at the top sample rate.
   logic [6:0] rows [9] = '{7'h00, 7'h45, 7'h09, 7'h4E, 7'h11, 7'h56,
                            7'h28, 7'h75, 7'h65};

   always #20 clk = ~clk;

   zf_sample_src src (.i_mclk(clk), .i_arst_n(rst_n), .i_zero_mask(zmask),
      .o_word_clock(wclk), .o_chan_data_zero(zero));

   // Ready is looped back because this is the only slave.
   zero_flag_gpo_oversample_ctrl #(.RUN_LEN(RL)) dut (.i_mclk(clk),
      .i_arst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata),
      .o_hresp(hresp), .i_word_clock(wclk), .i_chan_data_zero(zero),
      .o_shared_pin(pin), .o_channel_seven_zero_flag(f7),
      .o_channel_eight_zero_flag(f8), .o_all_channel_zero_flag(fall),
      .o_os_rate(os_rate), .o_irq(irq));

   // ==========================================================
   // Tasks
   task automatic give_verdict();
      if (fail_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One single transfer; the bench timeout is the only bound on waits.
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask

   // Let n edges pass, then sample away from the edge.
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // ==========================================================
   // Watchdog
   // The whole sequence needs well under two thousand cycles.
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      give_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      chk(os_rate, 32'h1);
      rst_n <= 1'b1;
      bus(0, `ZF_CTRL_OFS, 0);
      chk(r, 32'h0);
      bus(0, `ZF_CFG_OFS, 0);
      chk(r, 32'h0);
      bus(0, 8'h20, 0);
      chk(r, 32'h0);
      // Every clock ratio with one setting of the select bit, then three high-rate rows.
      foreach (rows[i]) begin
         bus(1, `ZF_CFG_OFS, {28'h0, rows[i][5:2]});
         bus(1, `ZF_CTRL_OFS, {24'h0, rows[i][6], 7'h0});
         wt(3);
         chk(os_rate, rows[i][1:0]);
         bus(0, `ZF_STAT_OFS, 0);
         chk(r[10:9], rows[i][1:0]);
      end
      // Zero runs on all channels: short of the count, then past it.
      bus(1, `ZF_CTRL_OFS, 0);
      bus(1, `ZF_IRQ_MASK_OFS, 32'h1FF);
      zmask <= 8'hFF;
      wt(4 * (RL - 2));
      chk({fall, pin}, 0);
      wt(24);
      chk({fall, f8, f7, pin}, 32'h1FF);
      chk(irq, 1);
      bus(0, `ZF_STAT_OFS, 0);
      chk(r[8:0], 32'h1FF);
      // Every channel onset and the combined onset stand as events.
      bus(0, `ZF_IRQ_STAT_OFS, 0);
      chk(r, 32'h1FF);
      bus(1, `ZF_IRQ_STAT_OFS, 32'h1FF);
      wt(2);
      chk(irq, 0);
      // Inverted polarity while the detects stand.
      bus(1, `ZF_CFG_OFS, 32'h10);
      wt(2);
      chk({fall, f8, f7, pin}, 0);
      bus(1, `ZF_CFG_OFS, 0);
      // General outputs take over the six shared pins only.
      bus(1, `ZF_CTRL_OFS, 32'h6A);
      wt(2);
      chk({f7, pin}, 32'h6A);
      bus(0, `ZF_CTRL_OFS, 0);
      chk(r, 32'h6A);
      bus(1, `ZF_CTRL_OFS, 0);
      // One nonzero sample on channel three drops its flag at once.
      zmask <= 8'hFB;
      wt(3);
      chk({fall, pin}, 32'h3B);
      // A reset in mid-run returns the outputs and the control word to their defaults.
      bus(1, `ZF_CTRL_OFS, 32'hFF);
      rst_n <= 1'b0;
      wt(2);
      chk({irq, fall, f8, f7, pin, os_rate}, 32'h1);
      @(posedge clk);
      rst_n <= 1'b1;
      bus(0, `ZF_CTRL_OFS, 0);
      chk(r, 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
